// ---- logic/sbc_top.sv ----
// Purpose: Break transmit path, baud control register and APB slave of a serial port
// Assumes: Single 10 MHz clock; rx_in and autobaud_ovf_in are synchronous to pclk
// Notes:   Zero-wait APB; read data is captured in the setup cycle
// Operation
// - Break is start bit, twelve low bits, then one stop bit.
// - Data write under break request starts break; written value discarded.
// - Break request clears itself after the break stop bit is sent.
// - Next byte is buffered during a break, sent normally afterwards.
// - Shift-empty flag shows busy during a break, idle afterwards.
// - Receiver stays idle while wake-on-edge is enabled.
// - Baud control bits 7,6 read-only; 4,3,1,0 writable; reset zero.
// - Overflow flag reads auto-baud overflow in async mode only.
// - Receiver idle flag low from start bit until reception ends.
// - Polarity inverts transmit idle and data async; selects rising edge sync.
// - Wake edge sets receive flag, no character, enable self-clears.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

module sbc_top
   import sbc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic rx_in,
   output logic tx_out,
   input wire logic autobaud_ovf_in,
   output logic autobaud_enable,
   output logic wide_rate_select,
   output logic sync_clock_rising,
   output logic irq
);

   // ***************************************************
   // Declarations
   // ***************************************************
   logic pol_q, wide_q, wake_q, abd_en_q;
   logic tx_en_q, brk_req_q, sync_q;
   logic buf_valid_q, buf_brk_q, brk_active_q;
   logic [7:0] buf_data_q;
   logic [7:0] rx_data_q, rx_shift_q;
   logic [IRQ_W-1:0] stat_q, mask_q, stat_set;
   logic [31:0] rd_mux, prdata_q;
   logic [7:0] baud_rd, txc_rd;
   logic [7:0] os_div_q;
   logic os_tick;
   logic setup_rd, acc, wr_en, rd_en, hit;
   logic wr_baud, wr_txc, wr_tx, wr_mask, rd_stat;
   logic load, accept, new_brk;
   logic busy, done, done_break, tx_line;
   logic rx_prev_q, rx_fall, rx_idle_flag, rx_done;
   sbc_rx_state_e rx_state_q;
   logic [3:0] rx_os_q, rx_bit_q;

   // ***************************************************
   // APB slave
   // ***************************************************
   // Every access completes in its first access cycle
   assign pready = 1'b1;
   assign acc = psel && penable;
   assign wr_en = acc && pwrite;
   assign rd_en = acc && !pwrite;
   assign setup_rd = psel && !penable && !pwrite;
   assign hit = (paddr == ADDR_BAUD) || (paddr == ADDR_TXCTRL) || (paddr == ADDR_TXDATA)
      || (paddr == ADDR_IRQMASK) || (paddr == ADDR_IRQSTAT) || (paddr == ADDR_RXDATA);
   assign pslverr = acc && !hit;
   assign wr_baud = wr_en && (paddr == ADDR_BAUD);
   assign wr_txc = wr_en && (paddr == ADDR_TXCTRL);
   assign wr_tx = wr_en && (paddr == ADDR_TXDATA);
   assign wr_mask = wr_en && (paddr == ADDR_IRQMASK);
   assign rd_stat = rd_en && (paddr == ADDR_IRQSTAT);

   // Flags that are meaningless in synchronous mode read as zero there
   assign rx_idle_flag = !sync_q && (rx_state_q == RX_IDLE);
   always_comb begin
      baud_rd = 8'h00;
      baud_rd[BAUD_ABD_OVF] = !sync_q && autobaud_ovf_in;
      baud_rd[BAUD_RX_IDLE] = rx_idle_flag;
      baud_rd[BAUD_POL] = pol_q;
      baud_rd[BAUD_WIDE] = wide_q;
      baud_rd[BAUD_WAKE] = wake_q;
      baud_rd[BAUD_ABD_EN] = abd_en_q;
      txc_rd = 8'h00;
      txc_rd[TXC_ENABLE] = tx_en_q;
      txc_rd[TXC_BREAK] = brk_req_q;
      txc_rd[TXC_SYNC] = sync_q;
      txc_rd[TXC_EMPTY] = !busy;
      txc_rd[TXC_BUF_FULL] = buf_valid_q;
   end

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      unique case (paddr)
         ADDR_BAUD: rd_mux = {24'h000000, baud_rd};
         ADDR_TXCTRL: rd_mux = {24'h000000, txc_rd};
         ADDR_IRQMASK: rd_mux = {29'h00000000, mask_q};
         ADDR_IRQSTAT: rd_mux = {29'h00000000, stat_q};
         ADDR_RXDATA: rd_mux = {24'h000000, rx_data_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Capture in setup so the access cycle presents stable data from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup_rd) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata = prdata_q;

   // ***************************************************
   // Baud control register
   // ***************************************************
   // Wake enable is cleared by the edge it waits for, unless rewritten that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_q <= BAUD_RESET[BAUD_POL];
         wide_q <= BAUD_RESET[BAUD_WIDE];
         wake_q <= BAUD_RESET[BAUD_WAKE];
         abd_en_q <= BAUD_RESET[BAUD_ABD_EN];
      end else begin
         if (wr_baud) begin
            pol_q <= pwdata[BAUD_POL];
            wide_q <= pwdata[BAUD_WIDE];
            abd_en_q <= pwdata[BAUD_ABD_EN];
         end
         if (wr_baud) begin
            wake_q <= pwdata[BAUD_WAKE];
         end else if (wake_q && rx_fall && !sync_q) begin
            wake_q <= 1'b0;
         end
      end
   end

   assign autobaud_enable = abd_en_q;
   assign wide_rate_select = wide_q;
   assign sync_clock_rising = sync_q && pol_q;

   // ***************************************************
   // Transmit control and buffer
   // ***************************************************
   // Software setting break request in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en_q <= TXCTRL_RESET[TXC_ENABLE];
         brk_req_q <= TXCTRL_RESET[TXC_BREAK];
         sync_q <= TXCTRL_RESET[TXC_SYNC];
      end else if (wr_txc) begin
         tx_en_q <= pwdata[TXC_ENABLE];
         brk_req_q <= pwdata[TXC_BREAK];
         sync_q <= pwdata[TXC_SYNC];
      end else if (done_break) begin
         brk_req_q <= 1'b0;
      end
   end

   // A byte written while a break is already under way is an ordinary character
   assign load = buf_valid_q && !busy && tx_en_q;
   assign accept = wr_tx && (!buf_valid_q || load);
   assign new_brk = brk_req_q && !brk_active_q && !(load && buf_brk_q);

   // One-entry holding buffer in front of the shifter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_valid_q <= 1'b0;
         buf_brk_q <= 1'b0;
         buf_data_q <= 8'h00;
      end else if (accept) begin
         buf_valid_q <= 1'b1;
         buf_brk_q <= new_brk;
         buf_data_q <= pwdata[7:0];
      end else if (load) begin
         buf_valid_q <= 1'b0;
      end
   end

   // Marks that the shifter holds a break; load sets it even if done clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_active_q <= 1'b0;
      end else if (load) begin
         brk_active_q <= buf_brk_q;
      end else if (done) begin
         brk_active_q <= 1'b0;
      end
   end

   // ***************************************************
   // Oversample divider and transmit shifter
   // ***************************************************
   // Free-running; tx restarts its own bit phase, rx aligns on the start edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         os_div_q <= 8'h00;
      end else if (os_div_q == 8'(OS_DIV_CYCLES - 1)) begin
         os_div_q <= 8'h00;
      end else begin
         os_div_q <= os_div_q + 8'h01;
      end
   end
   assign os_tick = (os_div_q == 8'(OS_DIV_CYCLES - 1));

   sbc_tx_shift u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .os_tick(os_tick),
      .load(load),
      .load_data(buf_data_q),
      .load_break(buf_brk_q),
      .invert(pol_q && !sync_q),
      .tx_line(tx_line),
      .busy(busy),
      .done(done),
      .done_break(done_break)
   );
   assign tx_out = tx_line;

   // ***************************************************
   // Receiver
   // ***************************************************
   assign rx_fall = rx_prev_q && !rx_in;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_in;
      end
   end

   // Mid-bit sampling; wake mode holds the receiver idle so no byte is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_q <= RX_IDLE;
         rx_os_q <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_shift_q <= 8'h00;
      end else if (wake_q || sync_q) begin
         rx_state_q <= RX_IDLE;
      end else if (rx_state_q == RX_IDLE) begin
         if (rx_fall) begin
            rx_state_q <= RX_START;
            rx_os_q <= 4'h0;
            rx_bit_q <= 4'h0;
         end
      end else if (os_tick) begin
         rx_os_q <= rx_os_q + 4'h1;
         if (rx_os_q == OS_MID) begin
            unique case (rx_state_q)
               RX_START: rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
               RX_DATA: begin
                  rx_shift_q <= {rx_in, rx_shift_q[7:1]};
                  if (rx_bit_q == DATA_LAST) begin
                     rx_state_q <= RX_STOP;
                  end
                  rx_bit_q <= rx_bit_q + 4'h1;
               end
               RX_STOP: rx_state_q <= RX_IDLE;
               RX_IDLE: rx_state_q <= RX_IDLE;
            endcase
         end
      end
   end
   assign rx_done = !wake_q && !sync_q && (rx_state_q == RX_STOP) && os_tick
      && (rx_os_q == OS_MID);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_q <= 8'h00;
      end else if (rx_done) begin
         rx_data_q <= rx_shift_q;
      end
   end

   // ***************************************************
   // Interrupts
   // ***************************************************
   always_comb begin
      stat_set = '0;
      stat_set[IRQ_BREAK_DONE] = done_break;
      stat_set[IRQ_RECEIVE] = rx_done || (wake_q && rx_fall && !sync_q);
      stat_set[IRQ_CHAR_DONE] = done && !done_break;
   end

   // Read clears, but an event in the same cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= IRQ_RESET;
      end else if (rd_stat) begin
         stat_q <= stat_set;
      end else begin
         stat_q <= stat_q | stat_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= IRQ_RESET;
      end else if (wr_mask) begin
         mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(stat_q & mask_q);

   // ***************************************************
   // Checks
   // ***************************************************
   break_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (done_break && !wr_txc) |=> !brk_req_q)
      else $error("break request not cleared after break");

   busy_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      load |=> txc_rd[TXC_EMPTY] == 1'b0 ##1 !txc_rd[TXC_EMPTY] [*2])
      else $error("shift empty flag wrong after load");

   queue_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
      (accept && brk_active_q && !load) |=> buf_valid_q && !buf_brk_q)
      else $error("byte during break not queued as normal");

   break_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (accept && brk_req_q && !brk_active_q && !buf_valid_q && !busy && tx_en_q)
      |=> buf_brk_q ##1 brk_active_q)
      else $error("data write under break request did not start break");

   wake_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      wake_q |=> rx_state_q == RX_IDLE)
      else $error("receiver left idle in wake mode");

   wake_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wake_q && rx_fall && !sync_q && !wr_baud) |=> !wake_q && stat_q[IRQ_RECEIVE])
      else $error("wake edge handling wrong");

   rx_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_state_q == RX_IDLE && rx_fall && !wake_q && !sync_q) |=> !rx_idle_flag)
      else $error("receiver idle flag high after start edge");

   ovf_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_rd && paddr == ADDR_BAUD) |=> prdata[BAUD_ABD_OVF] == ($past(!sync_q)
      && $past(autobaud_ovf_in)))
      else $error("overflow flag read wrong");

   idle_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!busy && $past(!busy) && $stable(pol_q) && $stable(sync_q))
      |-> tx_out == !(pol_q && !sync_q))
      else $error("idle line level ignores polarity");

   stat_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_stat && |stat_set) |=> |stat_q)
      else $error("event lost on read clear");

endmodule // sbc_top

`default_nettype wire

// ---- logic/sbc_pkg.sv ----
// Purpose: Shared constants and types for the serial break and baud control block
// Assumes: 10 MHz pclk, APB word-aligned registers (byte address = index * 4)
// Notes:   Every offset, field position, timing count and the baud, tx control and irq reset values live here

package sbc_pkg;

   // ***************************************************
   // Clock and timing
   // ***************************************************
   localparam int CLK_HZ = 10000000;
   localparam int BIT_RATE_BPS = 156250;
   localparam int OS_PER_BIT = 16;
   localparam int OS_DIV_CYCLES = CLK_HZ / (OS_PER_BIT * BIT_RATE_BPS);
   localparam logic [3:0] OS_LAST = 4'(OS_PER_BIT - 1);
   localparam logic [3:0] OS_MID = 4'(OS_PER_BIT / 2 - 1);
   localparam logic [3:0] DATA_LAST = 4'h7;
   localparam logic [3:0] BREAK_LAST = 4'hB;
   localparam int BREAK_ZERO_BITS = 12;

   // ***************************************************
   // Register indices and byte addresses
   // ***************************************************
   localparam logic [8:0] IDX_BAUD = 9'h11F;
   localparam logic [8:0] IDX_TXCTRL = 9'h11D;
   localparam logic [8:0] IDX_TXDATA = 9'h11C;
   localparam logic [8:0] IDX_IRQMASK = 9'h11B;
   localparam logic [8:0] IDX_IRQSTAT = 9'h11A;
   localparam logic [8:0] IDX_RXDATA = 9'h119;
   localparam logic [11:0] ADDR_BAUD = {1'b0, IDX_BAUD, 2'b00};
   localparam logic [11:0] ADDR_TXCTRL = {1'b0, IDX_TXCTRL, 2'b00};
   localparam logic [11:0] ADDR_TXDATA = {1'b0, IDX_TXDATA, 2'b00};
   localparam logic [11:0] ADDR_IRQMASK = {1'b0, IDX_IRQMASK, 2'b00};
   localparam logic [11:0] ADDR_IRQSTAT = {1'b0, IDX_IRQSTAT, 2'b00};
   localparam logic [11:0] ADDR_RXDATA = {1'b0, IDX_RXDATA, 2'b00};

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int BAUD_ABD_OVF = 7;
   localparam int BAUD_RX_IDLE = 6;
   localparam int BAUD_POL = 4;
   localparam int BAUD_WIDE = 3;
   localparam int BAUD_WAKE = 1;
   localparam int BAUD_ABD_EN = 0;
   localparam int TXC_ENABLE = 0;
   localparam int TXC_BREAK = 1;
   localparam int TXC_SYNC = 2;
   localparam int TXC_EMPTY = 3;
   localparam int TXC_BUF_FULL = 4;
   localparam int IRQ_W = 3;
   localparam int IRQ_BREAK_DONE = 0;
   localparam int IRQ_RECEIVE = 1;
   localparam int IRQ_CHAR_DONE = 2;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [7:0] TXCTRL_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // ***************************************************
   // State types
   // ***************************************************
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sbc_tx_state_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sbc_rx_state_e;

endpackage

// ---- logic/sbc_tx_shift.sv ----
// Purpose: Transmit shifter for ordinary characters and break characters
// Assumes: os_tick is a one-cycle pulse at sixteen times the bit rate
// Notes:   Line level is registered, so it trails the state by one cycle
`timescale 1ns/1ps
`default_nettype none

module sbc_tx_shift
   import sbc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic os_tick,
   input wire logic load,
   input wire logic [7:0] load_data,
   input wire logic load_break,
   input wire logic invert,
   output logic tx_line,
   output logic busy,
   output logic done,
   output logic done_break
);

   sbc_tx_state_e state_q;
   logic [3:0] os_q;
   logic [3:0] bit_q;
   logic [7:0] shreg_q;
   logic brk_q;
   logic level;
   logic bit_end;
   logic [15:0] low_cyc_q;

   assign bit_end = os_tick && (os_q == OS_LAST);
   assign busy = (state_q != TX_IDLE);

   // Frame sequencer: start, data or twelve zeros, stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= TX_IDLE;
         bit_q <= 4'h0;
         shreg_q <= 8'h00;
         brk_q <= 1'b0;
      end else if (state_q == TX_IDLE) begin
         if (load) begin
            state_q <= TX_START;
            bit_q <= 4'h0;
            shreg_q <= load_break ? 8'h00 : load_data;
            brk_q <= load_break;
         end
      end else if (bit_end) begin
         unique case (state_q)
            TX_START: begin
               state_q <= TX_DATA;
            end
            TX_DATA: begin
               // Break runs twelve zero bits, a character eight data bits
               if (bit_q == (brk_q ? BREAK_LAST : DATA_LAST)) begin
                  state_q <= TX_STOP;
               end else begin
                  bit_q <= bit_q + 4'h1;
                  shreg_q <= {1'b0, shreg_q[7:1]};
               end
            end
            TX_STOP: begin
               state_q <= TX_IDLE;
            end
            TX_IDLE: begin
               state_q <= TX_IDLE;
            end
         endcase
      end
   end

   // Oversample counter restarts with each frame so the start bit is full length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         os_q <= 4'h0;
      end else if (state_q == TX_IDLE) begin
         os_q <= 4'h0;
      end else if (os_tick) begin
         os_q <= os_q + 4'h1;
      end
   end

   // Completion pulses, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
         done_break <= 1'b0;
      end else begin
         done <= (state_q == TX_STOP) && bit_end;
         done_break <= (state_q == TX_STOP) && bit_end && brk_q;
      end
   end

   // Idle and stop are mark; polarity flips the whole line
   always_comb begin
      unique case (state_q)
         TX_START: level = 1'b0;
         TX_DATA: level = shreg_q[0];
         TX_STOP: level = 1'b1;
         TX_IDLE: level = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_line <= 1'b1;
      end else begin
         tx_line <= level ^ invert;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   // Cycles spent in the data phase of a break
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cyc_q <= 16'h0000;
      end else if (state_q == TX_DATA) begin
         low_cyc_q <= low_cyc_q + 16'h0001;
      end else begin
         low_cyc_q <= 16'h0000;
      end
   end

   break_length_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == TX_DATA && brk_q && bit_end && bit_q == BREAK_LAST)
      |-> low_cyc_q == 16'(BREAK_ZERO_BITS * OS_PER_BIT * OS_DIV_CYCLES - 1))
      else $error("break data phase has wrong length");

   break_zeros_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == TX_DATA && brk_q) |-> shreg_q == 8'h00)
      else $error("break sends a nonzero bit");

endmodule // sbc_tx_shift

`default_nettype wire

// ---- dv/sbc_line_node.sv ----
// Purpose: Serial line node facing the block, decodes frames and drives receive line
// Assumes: 64 pclk cycles per bit, non-inverted line while listening
// Notes:   Receive line always driven, idles high like a pulled-up bus
`timescale 1ns/1ps
`default_nettype none
module sbc_line_node
   import sbc_pkg::*;
(
   input wire logic pclk,
   input wire logic tx_out,
   input wire logic listen,
   output logic rx_in,
   output logic frame_valid,
   output logic [9:0] frame
);
   localparam int BITC = OS_DIV_CYCLES * OS_PER_BIT;
   logic [13:0] bits;
   initial begin
      rx_in = 1'b1;
      frame_valid = 1'b0;
      frame = 10'h000;
   end
   // Mid-bit sampler; a low tenth bit means a break, so sampling runs on
   always begin
      @(negedge tx_out);
      if (listen) begin
         bits = '1;
         repeat (BITC / 2) @(posedge pclk);
         for (int i = 0; i <= BREAK_ZERO_BITS + 1; i++) begin
            if (i > 0) repeat (BITC) @(posedge pclk);
            bits[i] = tx_out;
            if (i == 9 && tx_out) break;
         end
         frame <= {bits[13], bits[12:9] == 4'h0, bits[8:1]};
         frame_valid <= 1'b1;
         @(posedge pclk);
         frame_valid <= 1'b0;
      end
   end
   // Whole character, LSB first; caller enters just after a clock edge
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_in <= f[i];
         repeat (BITC) @(posedge pclk);
      end
   endtask
   // Short low glitch, enough for an edge but never a valid start bit
   task pulse;
      rx_in <= 1'b0;
      repeat (2) @(posedge pclk);
      rx_in <= 1'b1;
   endtask
endmodule // sbc_line_node
`default_nettype wire

// ---- dv/serial_break_and_baud_control_bench.sv ----
// Purpose: Self-checking bench for break path and baud control
// Assumes: APB master waits on pready; node decodes transmitted frames
// Notes:   Drivers queue expectations, monitors pop and compare them
`timescale 1ns/1ps
`default_nettype none
module serial_break_and_baud_control_bench
   import sbc_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic listen = 1'b1, ovf_in = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, tx_out, rx_in, abd_en, wide, sclk_rise, irq, fvalid;
   logic [31:0] prdata;
   logic [9:0] frame;
   logic [32:0] rd_q[$];
   logic [9:0] fr_q[$];
   logic [7:0] seed = 8'h35;
   int err_count = 0;
   int comparisons = 0;
   always #50 pclk = ~pclk;
   sbc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .autobaud_ovf_in(ovf_in),
      .autobaud_enable(abd_en), .wide_rate_select(wide), .sync_clock_rising(sclk_rise),
      .irq(irq));
   sbc_line_node node (.pclk(pclk), .tx_out(tx_out), .listen(listen), .rx_in(rx_in),
      .frame_valid(fvalid), .frame(frame));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task cmp_read(input logic [32:0] e, input logic [32:0] g);
      cmp("read", e, g);
   endtask
   task cmp_frame(input logic [9:0] e, input logic [9:0] g);
      cmp("frame", 33'(e), 33'(g));
   endtask
   // Read results and frames are compared in the order they were queued
   always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite)
      cmp_read(rd_q.pop_front(), {pslverr, prdata});
   always @(posedge pclk) if (fvalid === 1'b1)
      cmp_frame(fr_q.pop_front(), frame);
   // One transfer; entered and left just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task wait_frames;
      for (int i = 0; i < 4000 && fr_q.size() > 0; i++) @(posedge pclk);
      if (fr_q.size() > 0) cmp("frames left", 33'h0, 33'(fr_q.size()));
   endtask
   task end_sim;
      $display("Comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog, about five times the expected run
   initial begin
      #2000000;
      err_count++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Writable bits reset to zero; the idle receiver reports idle at once
      rd(ADDR_BAUD, 33'h40);
      rd(ADDR_TXCTRL, 33'h08);
      rd(12'h000, 33'h1_0000_0000);
      wr(ADDR_IRQMASK, 8'h07);
      // Read-only bits ignore writes; inverted line idles low, so stop listening
      listen <= 1'b0;
      wr(ADDR_BAUD, 8'hFF);
      rd(ADDR_BAUD, 33'h5B);
      cmp("line idle", 33'h0, 33'(tx_out));
      cmp("baud outs", 33'h3, {31'h0, abd_en, wide});
      ovf_in <= 1'b1;
      node.pulse();
      idle(2);
      rd(ADDR_BAUD, 33'hD9);
      cmp("irq", 33'h1, 33'(irq));
      rd(ADDR_IRQSTAT, 33'h02);
      cmp("irq", 33'h0, 33'(irq));
      // Sync mode hides both flags and turns polarity into edge choice
      wr(ADDR_TXCTRL, 8'h04);
      rd(ADDR_BAUD, 33'h19);
      cmp("edge sel", 33'h1, 33'(sclk_rise));
      wr(ADDR_TXCTRL, 8'h00);
      wr(ADDR_BAUD, 8'h00);
      ovf_in <= 1'b0;
      listen <= 1'b1;
      fork
         node.send(8'hC3);
         begin
            idle(200);
            rd(ADDR_BAUD, 33'h00);
         end
      join
      idle(64);
      rd(ADDR_RXDATA, 33'hC3);
      rd(ADDR_BAUD, 33'h40);
      rd(ADDR_IRQSTAT, 33'h02);
      // Frame header: break with random discarded byte, sync queued behind
      wr(ADDR_TXCTRL, 8'h03);
      seed = lfsr(seed);
      fr_q.push_back(10'h300);
      fr_q.push_back(10'h255);
      wr(ADDR_TXDATA, seed);
      wr(ADDR_TXDATA, 8'h55);
      rd(ADDR_TXCTRL, 33'h13);
      wait_frames;
      idle(70);
      rd(ADDR_TXCTRL, 33'h09);
      cmp("line idle", 33'h1, 33'(tx_out));
      rd(ADDR_IRQSTAT, 33'h05);
      for (int i = 0; i < 2; i++) begin
         seed = lfsr(seed);
         fr_q.push_back({2'b10, seed});
         wr(ADDR_TXDATA, seed);
      end
      wait_frames;
      idle(70);
      rd(ADDR_IRQSTAT, 33'h04);
      end_sim;
   end
endmodule // serial_break_and_baud_control_bench
`default_nettype wire
